// [rtl/cursor_ctrl_consts.svh]
// Register offsets, field positions and reset values of the cursor controls.
`ifndef CURSOR_CTRL_CONSTS_SVH
`define CURSOR_CTRL_CONSTS_SVH
// Indirect map index of the indirect control register.
`define IDX_CTRL_INDIRECT 8'h06
// Direct map offsets.
`define DIR_CTRL_DIRECT   4'h9
`define DIR_X_LOW         4'hC
`define DIR_X_HIGH        4'hD
`define DIR_Y_LOW         4'hE
`define DIR_Y_HIGH        4'hF
// Field positions in the indirect control register.
`define CCI_SRC_SEL       7
`define CCI_FIELD_INV     6
`define CCI_ILACE_EN      5
`define CCI_VBL_LEN       4
`define CCI_RAM_B9        3
`define CCI_RAM_B8        2
// Reset values of the control registers.
`define CTRL_RESET        8'h00
// Blank-gap lengths for vertical blank detection, in dot clocks.
`define VBL_SHORT_CLKS    13'h0800
`define VBL_LONG_CLKS     13'h1000
// Offset added on each axis from upper-left to the programmed corner.
`define CURSOR_CORNER_OFS 12'h040
`endif

// [rtl/cursor_ctrl_pkg.sv]
// Types shared by the cursor control register bank.
package cursor_ctrl_pkg;
  // Cursor display format.
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_THREE_COLOR,
    MODE_ALT_A,
    MODE_ALT_B
  } cursor_mode_t;
endpackage

// [rtl/hw_cursor_control_regs.sv]
// Cursor control and position register bank with blank-based vblank detect.
`timescale 1ns/1ps
`include "cursor_ctrl_consts.svh"
//
// Summary of operation
// R1: Select bit picks indirect or direct mode.
// R2: Firmware sets select bit for direct use.
// R3: Field indicator one on odd, invertible.
// R4: Interlace enable takes field from pin.
// R5: Vblank after 2048 or 4096 gap clocks.
// R6: Two control bits give RAM address 9:8.
// R7: Indirect mode: off, three-color, two alternates.
// R8: Direct mode bits 1:0; rest read zero.
// R9: Coordinates twelve bits, high nibble zero.
// R10: Coordinate is lower-right, upper-left plus 0x40.
// R11: Zero coordinate puts cursor off screen.
// R12: Position registers accessible anytime, no reset.
// R13: Mode change applies immediately.
module hw_cursor_control_regs #(
  parameter int VBL_CNT_W = 13
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ind_wr,
  input  wire logic [7:0]  ind_index,
  input  wire logic [7:0]  ind_wdata,
  output logic      [7:0]  ind_rdata,
  input  wire logic        dir_wr,
  input  wire logic [3:0]  dir_addr,
  input  wire logic [7:0]  dir_wdata,
  output logic      [7:0]  dir_rdata,
  input  wire logic        blank_pin,
  input  wire logic        field_pin,
  output cursor_ctrl_pkg::cursor_mode_t mode_eff,
  output logic      [1:0]  ram_addr_hi,
  output logic             interlace_on,
  output logic             odd_field,
  output logic             vblank,
  output logic      [11:0] corner_x,
  output logic      [11:0] corner_y,
  output logic             cursor_visible
);
  //----------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------
  logic [7:0]  ctrl_ind_reg;   // Indirect control register.
  logic [1:0]  ctrl_dir_reg;   // Direct mode field; upper bits not stored.
  logic [11:0] x_reg;          // Cursor X coordinate, no reset.
  logic [11:0] y_reg;          // Cursor Y coordinate, no reset.
  logic [1:0]  blank_sync;     // Blank input synchroniser.
  logic [1:0]  field_sync;     // Field input synchroniser.
  logic        blank_d;        // Previous synchronised blank.
  logic [VBL_CNT_W-1:0] gap_cnt; // Dot clocks since last blank rise, held once the gap is met.
  logic        gap_met;        // Required gap was reached.
  logic [1:0]  sel_mode;       // Mode from the selected register.
  logic [VBL_CNT_W-1:0] gap_need; // Required gap length.

  // Sign-free check that a coordinate places the cursor on screen.
  function automatic logic coord_on(input logic [11:0] c);
    coord_on = (c != 12'h000);
  endfunction

  //----------------------------------------------------------------
  // Control registers
  //----------------------------------------------------------------
  // Writes to both control registers; direct keeps only bits 1:0.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ind_reg <= `CTRL_RESET;
      ctrl_dir_reg <= 2'h0;
    end else begin
      if (ind_wr && ind_index == `IDX_CTRL_INDIRECT) begin
        ctrl_ind_reg <= ind_wdata;
      end
      if (dir_wr && dir_addr == `DIR_CTRL_DIRECT) begin
        ctrl_dir_reg <= dir_wdata[1:0]; // R8
      end
    end
  end

  // Position registers have no reset and are writable at any time.
  always_ff @(posedge clk) begin
    if (dir_wr) begin // R12
      case (dir_addr)
        `DIR_X_LOW:  x_reg[7:0]  <= dir_wdata;
        `DIR_X_HIGH: x_reg[11:8] <= dir_wdata[3:0]; // R9
        `DIR_Y_LOW:  y_reg[7:0]  <= dir_wdata;
        `DIR_Y_HIGH: y_reg[11:8] <= dir_wdata[3:0]; // R9
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------
  // Indirect read; unmapped indices read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      ind_rdata <= 8'h00;
    end else if (ind_index == `IDX_CTRL_INDIRECT) begin
      ind_rdata <= ctrl_ind_reg;
    end else begin
      ind_rdata <= 8'h00;
    end
  end

  // Direct read; reserved bits and unmapped offsets read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_rdata <= 8'h00;
    end else begin
      case (dir_addr)
        `DIR_CTRL_DIRECT: dir_rdata <= {6'h00, ctrl_dir_reg}; // R8
        `DIR_X_LOW:  dir_rdata <= x_reg[7:0];
        `DIR_X_HIGH: dir_rdata <= {4'h0, x_reg[11:8]}; // R9
        `DIR_Y_LOW:  dir_rdata <= y_reg[7:0];
        `DIR_Y_HIGH: dir_rdata <= {4'h0, y_reg[11:8]}; // R9
        default:     dir_rdata <= 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------
  // Mode and address outputs
  //----------------------------------------------------------------
  // The select bit picks which field governs the mode.
  always_comb begin
    sel_mode = ctrl_ind_reg[`CCI_SRC_SEL] ? ctrl_dir_reg // R1
                                          : ctrl_ind_reg[1:0];
  end

  // Effective mode, RAM address bits and interlace flag.
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_eff     <= cursor_ctrl_pkg::MODE_OFF;
      ram_addr_hi  <= 2'h0;
      interlace_on <= 1'b0;
    end else begin
      mode_eff     <= cursor_ctrl_pkg::cursor_mode_t'(sel_mode); // R7 R13
      ram_addr_hi  <= {ctrl_ind_reg[`CCI_RAM_B9],
                       ctrl_ind_reg[`CCI_RAM_B8]}; // R6
      interlace_on <= ctrl_ind_reg[`CCI_ILACE_EN]; // R4
    end
  end

  //----------------------------------------------------------------
  // Field indicator
  //----------------------------------------------------------------
  // Synchronise the field pin and apply the programmed sense.
  always_ff @(posedge clk) begin
    if (rst) begin
      field_sync <= 2'b00;
      odd_field  <= 1'b0;
    end else begin
      field_sync <= {field_sync[0], field_pin};
      odd_field  <= ctrl_ind_reg[`CCI_ILACE_EN] &
                    (field_sync[1] ^ ctrl_ind_reg[`CCI_FIELD_INV]); // R3 R4
    end
  end

  //----------------------------------------------------------------
  // Vertical blank detection
  //----------------------------------------------------------------
  // Gap length chosen by the detection bit.
  always_comb begin
    gap_need = ctrl_ind_reg[`CCI_VBL_LEN] ?
               VBL_CNT_W'(`VBL_LONG_CLKS) : VBL_CNT_W'(`VBL_SHORT_CLKS);
  end

  // Count dot clocks between blank rises; a long gap marks vblank.
  always_ff @(posedge clk) begin
    if (rst) begin
      blank_sync <= 2'b00;
      blank_d    <= 1'b0;
      gap_cnt    <= '0;
      gap_met    <= 1'b0;
      vblank     <= 1'b0;
    end else begin
      blank_sync <= {blank_sync[0], blank_pin};
      blank_d    <= blank_sync[1];
      if (blank_sync[1] && !blank_d) begin
        gap_cnt <= '0;
        gap_met <= 1'b0;
        vblank  <= gap_met; // R5
      end else if (!gap_met) begin
        gap_cnt <= gap_cnt + VBL_CNT_W'(1);
        // The flag is read one clock after it is set, so it is raised one
        // count early; a gap of exactly the required length then qualifies.
        gap_met <= (gap_cnt + VBL_CNT_W'(2)) >= gap_need; // R5
      end
      if (!blank_sync[1]) begin
        vblank <= 1'b0;
      end
    end
  end

  //----------------------------------------------------------------
  // Position outputs
  //----------------------------------------------------------------
  // The coordinate is the lower-right corner; zero hides the cursor.
  always_ff @(posedge clk) begin
    if (rst) begin
      corner_x       <= 12'h000;
      corner_y       <= 12'h000;
      cursor_visible <= 1'b0;
    end else begin
      corner_x       <= x_reg; // R10
      corner_y       <= y_reg; // R10
      cursor_visible <= coord_on(x_reg) & coord_on(y_reg) &
                        (sel_mode != 2'b00); // R11
    end
  end

  //----------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------
  sel_mode_a: assert property (@(posedge clk) disable iff (rst) // R1
    ##1 mode_eff == cursor_ctrl_pkg::cursor_mode_t'(
      $past(ctrl_ind_reg[`CCI_SRC_SEL]) ? $past(ctrl_dir_reg)
                                        : $past(ctrl_ind_reg[1:0])))
    else $error("effective mode not from selected register");
  field_sense_a: assert property (@(posedge clk) disable iff (rst) // R3
    ##1 odd_field == ($past(ctrl_ind_reg[`CCI_ILACE_EN]) &
      ($past(field_sync[1]) ^ $past(ctrl_ind_reg[`CCI_FIELD_INV]))))
    else $error("field indicator wrong");
  ram_addr_a: assert property (@(posedge clk) disable iff (rst) // R6
    ##1 ram_addr_hi == $past(ctrl_ind_reg[3:2]))
    else $error("cursor ram address high bits wrong");
  dir_resv_a: assert property (@(posedge clk) disable iff (rst) // R8
    ##1 ($past(dir_addr) == `DIR_CTRL_DIRECT) |-> dir_rdata[7:2] == 6'h00)
    else $error("direct control reserved bits nonzero");
  msb_zero_a: assert property (@(posedge clk) disable iff (rst) // R9
    ##1 ($past(dir_addr) == `DIR_X_HIGH || $past(dir_addr) == `DIR_Y_HIGH)
      |-> dir_rdata[7:4] == 4'h0)
    else $error("position high nibble nonzero");
  off_screen_a: assert property (@(posedge clk) disable iff (rst) // R11
    (x_reg == 12'h000 || y_reg == 12'h000) |=> !cursor_visible)
    else $error("cursor visible with zero coordinate");
  pos_write_a: assert property (@(posedge clk) disable iff (rst) // R12
    (dir_wr && dir_addr == `DIR_X_LOW) |=> x_reg[7:0] == $past(dir_wdata))
    else $error("x low write lost");
  vblank_gap_a: assert property (@(posedge clk) disable iff (rst) // R5
    $rose(vblank) |-> $past(gap_met))
    else $error("vblank without required gap");
  ilace_a: assert property (@(posedge clk) disable iff (rst) // R4
    !interlace_on |-> !odd_field)
    else $error("field indicator active without interlace");
endmodule

// [verification/cursor_host.sv]
// Host processor model that drives the cursor register port.
`timescale 1ns/1ps
`include "cursor_ctrl_consts.svh"
module cursor_host (
  input  wire logic       clk,
  output logic            ind_wr,
  output logic      [7:0] ind_index,
  output logic      [7:0] ind_wdata,
  output logic            dir_wr,
  output logic      [3:0] dir_addr,
  output logic      [7:0] dir_wdata,
  input  wire logic [7:0] ind_rdata,
  input  wire logic [7:0] dir_rdata
);
  // The port is idle with no strobe at time zero.
  initial begin
    {ind_wr, ind_index, ind_wdata, dir_wr, dir_addr, dir_wdata} = 30'h0;
  end
  // Writes one byte at a falling edge; sel picks the indirect map.
  task automatic wr(input logic sel, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    ind_index = a;
    dir_addr = a[3:0];
    ind_wdata = d;
    dir_wdata = d;
    ind_wr = sel;
    dir_wr = !sel;
    @(negedge clk);
    {ind_wr, dir_wr} = 2'h0;
    // Released data shows the inverse so stale bytes are never reused.
    ind_wdata = ~d;
    dir_wdata = ~d;
  endtask
  // Reads one byte; the answer is taken one cycle after the address.
  task automatic rd(input logic sel, input logic [7:0] a,
                    output logic [7:0] d);
    @(negedge clk);
    ind_index = a;
    dir_addr = a[3:0];
    @(negedge clk);
    d = sel ? ind_rdata : dir_rdata;
  endtask
  // Firmware hands mode control to the direct register.
  task automatic sel_direct(input logic [7:0] low);
    wr(1'b1, 8'h06, 8'h80 | low);
  endtask
  // Programs the lower-right corner from an upper-left position.
  task automatic place(input logic [11:0] x, input logic [11:0] y);
    logic [11:0] cx;
    logic [11:0] cy;
    cx = x + `CURSOR_CORNER_OFS;
    cy = y + `CURSOR_CORNER_OFS;
    wr(1'b0, 8'h0C, cx[7:0]);
    wr(1'b0, 8'h0D, {4'h0, cx[11:8]});
    wr(1'b0, 8'h0E, cy[7:0]);
    wr(1'b0, 8'h0F, {4'h0, cy[11:8]});
  endtask
endmodule

// [verification/hw_cursor_control_regs_bench.sv]
// Self-checking bench for the cursor control register bank.
`timescale 1ns/1ps
`include "cursor_ctrl_consts.svh"
module hw_cursor_control_regs_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        blank_pin = 1'b0;
  logic        field_pin = 1'b0;
  logic        ind_wr, dir_wr, interlace_on, odd_field, vblank, vis;
  logic [7:0]  ind_index, ind_wdata, ind_rdata, dir_wdata, dir_rdata, rv;
  logic [3:0]  dir_addr;
  logic [1:0]  ram_hi;
  logic [11:0] cx, cy;
  cursor_ctrl_pkg::cursor_mode_t mode;
  int          failures = 0;
  int          cmp_count = 0;
  // The clock toggles every 2.5 ns, half of its 5 ns period.
  always #2.5 clk = ~clk;
  hw_cursor_control_regs u_dut (.clk(clk), .rst(rst), .ind_wr(ind_wr),
    .ind_index(ind_index), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata),
    .dir_wr(dir_wr), .dir_addr(dir_addr), .dir_wdata(dir_wdata),
    .dir_rdata(dir_rdata), .blank_pin(blank_pin), .field_pin(field_pin),
    .mode_eff(mode), .ram_addr_hi(ram_hi), .interlace_on(interlace_on),
    .odd_field(odd_field), .vblank(vblank), .corner_x(cx), .corner_y(cy),
    .cursor_visible(vis));
  cursor_host u_host (.clk(clk), .ind_wr(ind_wr), .ind_index(ind_index),
    .ind_wdata(ind_wdata), .dir_wr(dir_wr), .dir_addr(dir_addr),
    .dir_wdata(dir_wdata), .ind_rdata(ind_rdata), .dir_rdata(dir_rdata));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  // Compares one result and counts it.
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads a register and compares the byte.
  task automatic rchk(input logic s, input logic [7:0] a, input logic [7:0] e);
    u_host.rd(s, a, rv);
    chk({4'h0, rv}, {4'h0, e});
  endtask
  // Lets a register change reach the derived outputs.
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  // Makes a blank gap of n clocks between rises, then checks vblank.
  task automatic gap(input int n, input logic e);
    blank_pin = 1'b1;
    repeat (4) @(negedge clk);
    blank_pin = 1'b0;
    repeat (n - 4) @(negedge clk);
    blank_pin = 1'b1;
    repeat (6) @(negedge clk);
    chk({11'h0, vblank}, {11'h0, e});
    blank_pin = 1'b0;
    // Blank stays low for one clock so that the next gap starts on a rise.
    @(negedge clk);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rchk(1'b1, 8'h06, 8'h00);
    rchk(1'b0, 8'h09, 8'h00);
    rchk(1'b1, 8'h07, 8'h00);
    rchk(1'b0, 8'h00, 8'h00);
    // Every mode code through both registers, switching source each pass.
    for (int m = 0; m < 4; m++) begin
      u_host.wr(1'b1, 8'h06, 8'h0C | m[7:0]);
      u_host.wr(1'b0, 8'h09, 8'hFC | (8'h03 - m[7:0]));
      settle();
      chk({10'h0, mode}, m[11:0]);
      chk({10'h0, ram_hi}, 12'h003);
      rchk(1'b0, 8'h09, 8'h03 - m[7:0]);
      u_host.sel_direct(8'h08 | m[7:0]);
      settle();
      chk({10'h0, mode}, 12'h003 - m[11:0]);
      chk({10'h0, ram_hi}, 12'h002);
    end
    // Position at the top of range, then out of range and zero.
    u_host.place(12'hFBF, 12'h000);
    u_host.wr(1'b0, 8'h09, 8'h01);
    settle();
    chk(cx, 12'hFFF);
    chk(cy, 12'h040);
    chk({11'h0, vis}, 12'h001);
    u_host.wr(1'b0, 8'h0D, 8'hF0);
    rchk(1'b0, 8'h0D, 8'h00);
    u_host.wr(1'b0, 8'h0C, 8'h00);
    settle();
    chk({11'h0, vis}, 12'h000);
    rchk(1'b0, 8'h0E, 8'h40);
    // Field sense, normal and inverted, then interlace off.
    field_pin = 1'b1;
    u_host.wr(1'b1, 8'h06, 8'hA0);
    settle();
    chk({10'h0, interlace_on, odd_field}, 12'h003);
    u_host.wr(1'b1, 8'h06, 8'hE0);
    settle();
    chk({11'h0, odd_field}, 12'h000);
    field_pin = 1'b0;
    settle();
    chk({11'h0, odd_field}, 12'h001);
    u_host.wr(1'b1, 8'h06, 8'h80);
    settle();
    chk({10'h0, interlace_on, odd_field}, 12'h000);
    // Blank gaps of exactly each length and one clock short of it.
    gap(2048, 1'b1);
    gap(2047, 1'b0);
    u_host.wr(1'b1, 8'h06, 8'h10);
    gap(4096, 1'b1);
    gap(4095, 1'b0);
    end_sim();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
